// File: uepb_pkg.sv
// Purpose: Shared constants and carrier types for the endpoint buffer register block.
// Assumes: AHB-Lite word registers; byte address is four times the register index.
// Notes:   Field positions follow the selector, control and packet limit layouts.
package uepb_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] UEPB_IDX_PKT_LIMIT = 6'h04;
  localparam logic [5:0] UEPB_IDX_PKT_LEN   = 6'h1c;
  localparam logic [5:0] UEPB_IDX_FILL      = 6'h1e;
  localparam logic [5:0] UEPB_IDX_DATA      = 6'h20;
  localparam logic [5:0] UEPB_IDX_CTRL      = 6'h28;
  localparam logic [5:0] UEPB_IDX_SEL       = 6'h2c;
  localparam logic [5:0] UEPB_IDX_NONE      = 6'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UEPB_CTRL_HALT    = 0;
  localparam int UEPB_CTRL_STATUS  = 1;
  localparam int UEPB_CTRL_GO      = 2;
  localparam int UEPB_CTRL_TXREADY = 3;
  localparam int UEPB_CTRL_DISCARD = 4;
  localparam int UEPB_SIZE_MSB     = 10;
  localparam int UEPB_NTR_LSB      = 11;
  localparam int UEPB_NTR_MSB      = 12;

  // ----------------------------------------------------------------
  // Sizes, reset values and bus codes
  // ----------------------------------------------------------------
  localparam int          UEPB_NUM_BUF     = 32;
  localparam logic [6:0]  UEPB_BANK_BYTES  = 7'h40;
  localparam logic [3:0]  UEPB_SETUP_BYTES = 4'h8;
  localparam logic [12:0] UEPB_LIMIT_RST   = 13'h0000;
  localparam logic [15:0] UEPB_LEN_RST     = 16'h0000;
  localparam logic [1:0]  UEPB_HRESP_OKAY  = 2'h0;

  typedef struct packed {
    logic       setup;
    logic [3:0] ep;
    logic       dir;
  } uepb_sel_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] idx;
  } uepb_req_type;

endpackage

// File: uepb_regs.sv
// Purpose: Indexed endpoint buffer registers and packet buffers behind an AHB-Lite slave.
// Assumes: Single 25 MHz clock; the serial engine side is synchronous pulses and levels.
// Notes:   Each endpoint direction owns two banks of 64 bytes; endpoint 0 uses one bank.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps

module uepb_regs
  import uepb_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  // Serial engine events
  input  wire logic        usb_bus_reset,
  input  wire logic [3:0]  sie_ep,
  input  wire logic        sie_rx_write,
  input  wire logic        sie_rx_setup,
  input  wire logic [4:0]  sie_rx_word,
  input  wire logic [15:0] sie_rx_data,
  input  wire logic        sie_rx_done,
  input  wire logic [10:0] sie_rx_len,
  input  wire logic [4:0]  sie_tx_word,
  input  wire logic        sie_tx_sent,
  input  wire logic        sie_setup,
  input  wire logic        sie_status_done,
  // Serial engine status
  output logic      [15:0] sie_tx_data,
  output logic      [10:0] sie_tx_len,
  output logic             sie_tx_avail,
  output logic             sie_rx_room,
  output logic      [1:0]  transactions_per_microframe,
  output logic      [31:0] ep_halted,
  output logic             control_data_stage_go,
  output logic             ep0_status_ack
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  uepb_req_type    ap_r;
  logic            rd_wait_r;
  logic [31:0]     hrdata_r;
  uepb_sel_type    sel_r;
  logic [12:0]     limit_r   [UEPB_NUM_BUF];
  logic [15:0]     plen_r    [UEPB_NUM_BUF];
  logic [1:0]      fill_r    [UEPB_NUM_BUF];
  logic            cbank_r   [UEPB_NUM_BUF];
  logic            sbank_r   [UEPB_NUM_BUF];
  logic [6:0]      cnt_r     [UEPB_NUM_BUF];
  logic [10:0]     blen_r    [2*UEPB_NUM_BUF];
  logic [15:0]     mem_r     [64*UEPB_NUM_BUF];
  logic [15:0]     setup_mem_r [4];
  logic            setup_full_r;
  logic [3:0]      setup_cnt_r;
  logic [31:0]     halt_r;
  logic            go_r;
  logic            stat_r;
  logic [15:0]     sie_tx_data_r;
  logic [10:0]     sie_tx_len_r;
  logic            sie_tx_avail_r;
  logic            sie_rx_room_r;
  logic [1:0]      ntrans_r;

  // Decoding of an endpoint and direction into a buffer number, used for both sides.
  function automatic logic [4:0] buf_of(input logic [3:0] ep, input logic dir);
    buf_of = {ep, dir};
  endfunction

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic        clr;
  logic        take;
  logic        rd_do;
  logic [4:0]  cur;
  logic        cb;
  logic        cur_full;
  logic        is_ep0;
  logic        setup_sel;
  logic [6:0]  ncnt;
  logic [10:0] fsz;
  logic        wr_data;
  logic        wr_ctrl;
  logic        tx_wr;
  logic        tx_hit;
  logic        tx_mark;
  logic [6:0]  tx_len;
  logic        rx_rd;
  logic        rx_free;
  logic        su_rd;
  logic [4:0]  s_rx;
  logic [4:0]  s_tx;
  logic        rx_take;
  logic        tx_sent;

  always_comb begin
    clr       = ~rst_b | usb_bus_reset;
    take      = hsel & hready & htrans[1];
    rd_do     = ap_r.valid & ~ap_r.write & ~rd_wait_r;
    cur       = buf_of(sel_r.ep, sel_r.dir);
    cb        = cbank_r[cur];
    cur_full  = fill_r[cur][cb];
    is_ep0    = (sel_r.ep == 4'h0);
    setup_sel = sel_r.setup & is_ep0;
    ncnt      = cnt_r[cur] + 7'h02;
    fsz       = limit_r[cur][UEPB_SIZE_MSB:0];
    wr_data   = ap_r.valid & ap_r.write & (ap_r.idx == UEPB_IDX_DATA);
    wr_ctrl   = ap_r.valid & ap_r.write & (ap_r.idx == UEPB_IDX_CTRL);
    tx_wr     = wr_data & sel_r.dir & ~setup_sel & ~cur_full;
    tx_hit    = ((fsz != 11'h000) && ({4'h0, ncnt} >= fsz))
              | ((plen_r[cur] != UEPB_LEN_RST) && ({9'h000, ncnt} >= plen_r[cur]))
              | (ncnt >= UEPB_BANK_BYTES);
    tx_mark   = (tx_wr & tx_hit)
              | (wr_ctrl & hwdata[UEPB_CTRL_TXREADY] & sel_r.dir & ~cur_full);
    tx_len    = tx_wr ? ncnt : cnt_r[cur];
    rx_rd     = rd_do & (ap_r.idx == UEPB_IDX_DATA) & ~sel_r.dir & ~setup_sel & cur_full;
    rx_free   = (rx_rd & ({4'h0, ncnt} >= blen_r[{cur, cb}]))
              | (wr_ctrl & hwdata[UEPB_CTRL_DISCARD] & ~sel_r.dir & cur_full);
    su_rd     = rd_do & (ap_r.idx == UEPB_IDX_DATA) & setup_sel & setup_full_r;
    s_rx      = buf_of(sie_ep, 1'b0);
    s_tx      = buf_of(sie_ep, 1'b1);
    rx_take   = sie_rx_done & ~sie_rx_setup & ~fill_r[s_rx][sbank_r[s_rx]];
    tx_sent   = sie_tx_sent & fill_r[s_tx][sbank_r[s_tx]];
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes have no wait state, reads take one
  // ----------------------------------------------------------------
  // The extra read cycle lets the data port pop happen once, with the word
  // registered before it is presented.
  assign hreadyout = ~rd_do;
  assign hresp     = UEPB_HRESP_OKAY;
  assign hrdata    = hrdata_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ap_r      <= '0;
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= rd_do;
      if (hready) begin
        ap_r.valid <= take;
        ap_r.write <= hwrite;
        ap_r.idx   <= (haddr[31:8] == 24'h000000) ? haddr[7:2] : UEPB_IDX_NONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_do) begin
      unique case (ap_r.idx)
        UEPB_IDX_PKT_LIMIT: hrdata_r <= {19'h00000, limit_r[cur]};
        UEPB_IDX_PKT_LEN:   hrdata_r <= {16'h0000, plen_r[cur]};
        UEPB_IDX_FILL:      hrdata_r <= {30'h00000000, is_ep0 ? 2'b00 : fill_r[cur]};
        UEPB_IDX_DATA: begin
          if (su_rd) begin
            hrdata_r <= {16'h0000, setup_mem_r[setup_cnt_r[2:1]]};
          end else if (rx_rd) begin
            hrdata_r <= {16'h0000, mem_r[{cur, cb, cnt_r[cur][5:1]}]};
          end else begin
            hrdata_r <= 32'h00000000;
          end
        end
        UEPB_IDX_CTRL:      hrdata_r <= {29'h00000000, is_ep0 & go_r, is_ep0 & stat_r,
                                         halt_r[cur]};
        UEPB_IDX_SEL:       hrdata_r <= {26'h0000000, sel_r};
        default:            hrdata_r <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      sel_r <= '0;
    end else if (ap_r.valid && ap_r.write && ap_r.idx == UEPB_IDX_SEL) begin
      sel_r <= hwdata[5:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < UEPB_NUM_BUF; b++) begin
      if (clr) begin
        limit_r[b] <= UEPB_LIMIT_RST;
        plen_r[b]  <= UEPB_LEN_RST;
      end else begin
        if (ap_r.valid && ap_r.write && ap_r.idx == UEPB_IDX_PKT_LIMIT) begin
          plen_r[b] <= {5'h00, hwdata[UEPB_SIZE_MSB:0]};
          if (b == 32'(cur)) begin
            limit_r[b] <= hwdata[UEPB_NTR_MSB:0];
          end
        end
        if (ap_r.valid && ap_r.write && ap_r.idx == UEPB_IDX_PKT_LEN && b == 32'(cur)) begin
          plen_r[b] <= hwdata[15:0];
        end
        if (rx_take && b == 32'(s_rx)) begin
          plen_r[b] <= {5'h00, sie_rx_len};
        end
      end
    end
  end

  // Halt is stored per endpoint direction; the serial engine ignores it for
  // isochronous endpoints, and the data toggle is left where it stopped.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      halt_r <= 32'h00000000;
    end else if (wr_ctrl) begin
      halt_r[cur] <= hwdata[UEPB_CTRL_HALT];
    end
  end

  // A software write in the same cycle as a hardware clear wins, so a fresh
  // answer for the next transfer is never lost.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      go_r   <= 1'b0;
      stat_r <= 1'b0;
    end else if (wr_ctrl && is_ep0) begin
      go_r   <= hwdata[UEPB_CTRL_GO];
      stat_r <= hwdata[UEPB_CTRL_STATUS];
    end else begin
      if (sie_setup) begin
        go_r <= 1'b0;
      end
      if (sie_setup || sie_status_done) begin
        stat_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank ownership and fill state
  // ----------------------------------------------------------------
  // Set and clear of a fill bit never meet on the same bank: engine and software
  // alike fill only an empty bank and drain only a full one.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      for (int b = 0; b < UEPB_NUM_BUF; b++) begin
        fill_r[b]  <= 2'b00;
        cbank_r[b] <= 1'b0;
        sbank_r[b] <= 1'b0;
        cnt_r[b]   <= 7'h00;
      end
    end else begin
      if (rx_take) begin
        fill_r[s_rx][sbank_r[s_rx]] <= 1'b1;
        sbank_r[s_rx] <= sbank_r[s_rx] ^ (sie_ep != 4'h0);
      end
      if (tx_sent) begin
        fill_r[s_tx][sbank_r[s_tx]] <= 1'b0;
        sbank_r[s_tx] <= sbank_r[s_tx] ^ (sie_ep != 4'h0);
      end
      if (tx_wr || rx_rd) begin
        cnt_r[cur] <= ncnt;
      end
      if (tx_mark) begin
        fill_r[cur][cb] <= 1'b1;
        cbank_r[cur]    <= cb ^ ~is_ep0;
        cnt_r[cur]      <= 7'h00;
      end
      if (rx_free) begin
        fill_r[cur][cb] <= 1'b0;
        cbank_r[cur]    <= cb ^ ~is_ep0;
        cnt_r[cur]      <= 7'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      setup_full_r <= 1'b0;
      setup_cnt_r  <= 4'h0;
    end else if (sie_rx_done && sie_rx_setup) begin
      setup_full_r <= 1'b1;
      setup_cnt_r  <= 4'h0;
    end else if (su_rd) begin
      setup_cnt_r <= setup_cnt_r + 4'h2;
      if (setup_cnt_r + 4'h2 >= UEPB_SETUP_BYTES) begin
        setup_full_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rx_take) begin
      blen_r[{s_rx, sbank_r[s_rx]}] <= sie_rx_len;
    end
    if (tx_mark) begin
      blen_r[{cur, cb}] <= {4'h0, tx_len};
    end
  end

  // Words are stored low byte first, so an odd last byte sits in bits 7..0.
  always_ff @(posedge sys_clk) begin
    if (sie_rx_write && !sie_rx_setup) begin
      mem_r[{s_rx, sbank_r[s_rx], sie_rx_word}] <= sie_rx_data;
    end
    if (tx_wr) begin
      mem_r[{cur, cb, cnt_r[cur][5:1]}] <= hwdata[15:0];
    end
    if (sie_rx_write && sie_rx_setup) begin
      setup_mem_r[sie_rx_word[1:0]] <= sie_rx_data;
    end
  end

  // ----------------------------------------------------------------
  // Serial engine status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      sie_tx_data_r  <= 16'h0000;
      sie_tx_len_r   <= 11'h000;
      sie_tx_avail_r <= 1'b0;
      sie_rx_room_r  <= 1'b0;
      ntrans_r       <= 2'b00;
    end else begin
      sie_tx_data_r  <= mem_r[{s_tx, sbank_r[s_tx], sie_tx_word}];
      sie_tx_len_r   <= blen_r[{s_tx, sbank_r[s_tx]}];
      sie_tx_avail_r <= fill_r[s_tx][sbank_r[s_tx]];
      sie_rx_room_r  <= ~fill_r[s_rx][sbank_r[s_rx]];
      ntrans_r       <= limit_r[s_tx][UEPB_NTR_MSB:UEPB_NTR_LSB];
    end
  end

  assign sie_tx_data                 = sie_tx_data_r;
  assign sie_tx_len                  = sie_tx_len_r;
  assign sie_tx_avail                = sie_tx_avail_r;
  assign sie_rx_room                 = sie_rx_room_r;
  assign transactions_per_microframe = ntrans_r;
  assign ep_halted                   = halt_r;
  assign control_data_stage_go       = go_r;
  assign ep0_status_ack              = stat_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not complete after exactly one wait state");

  a_len_bus_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    usb_bus_reset |=> (plen_r[cur] == 16'h0000))
    else $error("packet length not cleared by bus reset");

  a_limit_reload: assert property (@(posedge sys_clk) disable iff (clr)
    (ap_r.valid && ap_r.write && ap_r.idx == UEPB_IDX_PKT_LIMIT)
      |=> (plen_r[0] == {5'h00, $past(hwdata[10:0])}))
    else $error("packet lengths not reloaded from new size");

  a_tx_auto_ready: assert property (@(posedge sys_clk) disable iff (clr)
    (tx_wr && fsz != 11'h000 && {4'h0, ncnt} >= fsz) |=> fill_r[$past(cur)][$past(cb)])
    else $error("full transmit buffer not marked ready");

  a_rx_auto_free: assert property (@(posedge sys_clk) disable iff (clr)
    (rx_rd && {4'h0, ncnt} >= blen_r[{cur, cb}] && !rx_take)
      |=> !fill_r[$past(cur)][$past(cb)])
    else $error("drained receive buffer not freed");

  a_ack_len_load: assert property (@(posedge sys_clk) disable iff (clr)
    (rx_take && !(ap_r.valid && ap_r.write))
      |=> (plen_r[$past(s_rx)] == {5'h00, $past(sie_rx_len)}))
    else $error("packet length not loaded with received count");

  a_status_clear: assert property (@(posedge sys_clk) disable iff (clr)
    ((sie_setup || sie_status_done) && !wr_ctrl)
      |=> !ep0_status_ack ##1 (!ep0_status_ack || $past(wr_ctrl && is_ep0)))
    else $error("status acknowledge not cleared by hardware");

  a_halt_write: assert property (@(posedge sys_clk) disable iff (clr)
    wr_ctrl |=> (ep_halted[$past(cur)] == $past(hwdata[0])))
    else $error("halt bit does not follow control write");

  a_two_byte_step: assert property (@(posedge sys_clk) disable iff (clr)
    (tx_wr && !tx_mark) |=> (cnt_r[$past(cur)] == $past(cnt_r[cur]) + 7'h02))
    else $error("write count did not advance by two");

endmodule

// File: uepb_sie_model.sv
// Purpose: Serial engine model that delivers OUT packets and fetches IN data.
// Assumes: It drives just after the rising edge; block outputs lag one cycle.
// Notes:   A released data line shows the inverse of its last word, not a stale copy.
`timescale 1ns/1ps

module uepb_sie_model
  import uepb_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Engine requests
  output logic      [3:0]  sie_ep = 4'h0,
  output logic             sie_rx_write = 1'b0,
  output logic             sie_rx_setup = 1'b0,
  output logic      [4:0]  sie_rx_word = 5'h00,
  output logic      [15:0] sie_rx_data = 16'h0000,
  output logic             sie_rx_done = 1'b0,
  output logic      [10:0] sie_rx_len = 11'h000,
  output logic      [4:0]  sie_tx_word = 5'h00,
  output logic             sie_tx_sent = 1'b0,
  output logic             sie_setup = 1'b0,
  output logic             sie_status_done = 1'b0,
  // Block answer
  input  wire logic [15:0] sie_tx_data
);
  logic [15:0] mem [0:31];

  task automatic rx_pkt(input logic [3:0] ep, input logic su, input logic [10:0] len);
    int i;
    @(posedge sys_clk);
    sie_ep       <= ep;
    sie_rx_setup <= su;
    for (i = 0; i < (int'(len) + 1) / 2; i++) begin
      @(posedge sys_clk);
      sie_rx_write <= 1'b1;
      sie_rx_word  <= 5'(i);
      sie_rx_data  <= mem[i];
    end
    @(posedge sys_clk);
    sie_rx_write <= 1'b0;
    sie_rx_data  <= ~sie_rx_data;
    sie_rx_done  <= 1'b1;
    sie_rx_len   <= len;
    @(posedge sys_clk);
    sie_rx_done  <= 1'b0;
    sie_rx_setup <= 1'b0;
  endtask

  // The word comes back one cycle after the request, so three edges is ample.
  task automatic tx_word(input logic [3:0] ep, input logic [4:0] w, output logic [15:0] d);
    @(posedge sys_clk);
    sie_ep      <= ep;
    sie_tx_word <= w;
    repeat (3) @(posedge sys_clk);
    d = sie_tx_data;
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge sys_clk);
    {sie_tx_sent, sie_setup, sie_status_done} <= m;
    @(posedge sys_clk);
    {sie_tx_sent, sie_setup, sie_status_done} <= 3'h0;
    // One more edge so the block's registered answer has settled on return.
    @(posedge sys_clk);
  endtask
endmodule

// File: uepb_tb.sv
// Purpose: Self-checking bench for the endpoint buffer register block.
// Assumes: One AHB-Lite master and one slave; the serial engine is a model.
// Notes:   Buffer sizes stay at 64 bytes or less, so every buffer fits.
`timescale 1ns/1ps

module testbench
  import uepb_pkg::*;
;
  logic        sys_clk, rst_b, hsel, hwrite, hreadyout, usb_bus_reset, sie_rx_write;
  logic [2:0]  hsize;
  logic        sie_rx_setup, sie_rx_done, sie_tx_sent, sie_setup, sie_status_done;
  logic        sie_tx_avail, sie_rx_room, control_data_stage_go, ep0_status_ack;
  logic [1:0]  htrans, hresp, transactions_per_microframe;
  logic [31:0] haddr, hwdata, hrdata, r, ep_halted;
  logic [15:0] sie_tx_data, sie_rx_data, d;
  logic [15:0] tw [0:3];
  logic [10:0] sie_tx_len, sie_rx_len, sz;
  logic [4:0]  sie_rx_word, sie_tx_word;
  logic [3:0]  sie_ep, ep;
  int          checks = 0, error_cnt = 0, i, k;

  uepb_regs DUT (
    .sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .usb_bus_reset,
    .sie_ep, .sie_rx_write, .sie_rx_setup, .sie_rx_word, .sie_rx_data, .sie_rx_done,
    .sie_rx_len, .sie_tx_word, .sie_tx_sent, .sie_setup, .sie_status_done,
    .sie_tx_data, .sie_tx_len, .sie_tx_avail, .sie_rx_room, .transactions_per_microframe,
    .ep_halted, .control_data_stage_go, .ep0_status_ack
  );

  uepb_sie_model sie (
    .sys_clk, .sie_ep, .sie_rx_write, .sie_rx_setup, .sie_rx_word, .sie_rx_data,
    .sie_rx_done, .sie_rx_len, .sie_tx_word, .sie_tx_sent, .sie_setup,
    .sie_status_done, .sie_tx_data
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A hung slave would stall the bench, so every wait is bounded.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 40) begin
        error_cnt++;
        final_report();
      end
      @(posedge sys_clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    haddr  <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    wait_rdy();
    r = hrdata;
    chk("hresp", 16'(hresp), 16'(UEPB_HRESP_OKAY));
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    bus(1'b1, idx, v);
  endtask

  task automatic rd(input logic [5:0] idx);
    bus(1'b0, idx, 16'h0);
  endtask

  function automatic logic [15:0] nfill(input logic [1:0] f);
    return 16'(f[0]) + 16'(f[1]);
  endfunction

  function automatic logic [15:0] lane(input logic odd_last);
    return odd_last ? 16'h00ff : 16'hffff;
  endfunction

  initial begin
    rst_b = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsel = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    usb_bus_reset = 1'b0;
    void'($urandom(32'hdcf41f9e));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(UEPB_IDX_PKT_LEN);
    chk("len_reset", r[15:0], UEPB_LEN_RST);
    rd(UEPB_IDX_NONE);
    chk("unmapped", r[15:0], 16'h0000);
    for (k = 0; k < 3; k++) begin
      ep = 4'(1 + $urandom_range(14));
      sz = 11'(8 * (1 + $urandom_range(7)));
      wr(UEPB_IDX_SEL, {11'h0, ep, 1'b1});
      wr(UEPB_IDX_PKT_LIMIT, {3'h0, 2'(k), sz});
      sie.tx_word(ep, 5'h00, d);
      chk("ntrans", 16'(transactions_per_microframe), 16'(k));
      wr(UEPB_IDX_CTRL, 16'h0001);
      @(posedge sys_clk);
      chk("halt", 16'(ep_halted[{ep, 1'b1}]), 16'h1);
      wr(UEPB_IDX_CTRL, 16'h0000);
      wr(UEPB_IDX_SEL, {11'h0, ep - 4'h1, 1'b0});
      rd(UEPB_IDX_PKT_LEN);
      chk("len_reload", r[15:0], 16'(sz));
    end
    wr(UEPB_IDX_SEL, 16'h0005);
    wr(UEPB_IDX_PKT_LIMIT, 16'h0008);
    sie.tx_word(4'h2, 5'h00, d);
    for (i = 0; i < 4; i++) begin
      tw[i] = 16'($urandom);
      wr(UEPB_IDX_DATA, tw[i]);
      if (i == 2) begin
        repeat (2) @(posedge sys_clk);
        chk("tx_early", 16'(sie_tx_avail), 16'h0);
      end
    end
    for (i = 0; i < 4; i++) begin
      sie.tx_word(4'h2, 5'(i), d);
      chk("tx_word", d, tw[i]);
    end
    chk("tx_full", {5'h0, sie_tx_len}, 16'h8);
    sie.pulse(3'h4);
    wr(UEPB_IDX_PKT_LEN, 16'h0006);
    for (i = 0; i < 3; i++) wr(UEPB_IDX_DATA, 16'($urandom));
    repeat (2) @(posedge sys_clk);
    chk("tx_short", {4'h0, sie_tx_len, sie_tx_avail}, 16'hd);
    sie.pulse(3'h4);
    wr(UEPB_IDX_DATA, 16'($urandom));
    repeat (2) @(posedge sys_clk);
    chk("tx_hold", 16'(sie_tx_avail), 16'h0);
    wr(UEPB_IDX_CTRL, 16'h0008);
    repeat (2) @(posedge sys_clk);
    chk("tx_mark", {4'h0, sie_tx_len, sie_tx_avail}, 16'h5);
    sie.pulse(3'h4);
    for (i = 0; i < 4; i++) sie.mem[i] = 16'($urandom);
    sie.rx_pkt(4'h3, 1'b0, 11'd5);
    wr(UEPB_IDX_SEL, 16'h0006);
    rd(UEPB_IDX_PKT_LEN);
    chk("rx_len", r[15:0], 16'h5);
    sie.rx_pkt(4'h3, 1'b0, 11'd5);
    rd(UEPB_IDX_FILL);
    chk("fill_two", nfill(r[1:0]), 16'h2);
    chk("rx_room", 16'(sie_rx_room), 16'h0);
    for (k = 2; k > 0; k--) begin
      for (i = 0; i < 3; i++) begin
        rd(UEPB_IDX_DATA);
        chk("rx_word", r[15:0] & lane(i == 2), sie.mem[i] & lane(i == 2));
      end
      rd(UEPB_IDX_FILL);
      chk("fill_free", nfill(r[1:0]), 16'(k - 1));
    end
    chk("rx_room_free", 16'(sie_rx_room), 16'h1);
    sie.rx_pkt(4'h3, 1'b0, 11'd5);
    wr(UEPB_IDX_CTRL, 16'h0010);
    rd(UEPB_IDX_FILL);
    chk("discard", nfill(r[1:0]), 16'h0);
    sie.rx_pkt(4'h0, 1'b1, 11'd8);
    wr(UEPB_IDX_SEL, 16'h0020);
    for (i = 0; i < 4; i++) begin
      rd(UEPB_IDX_DATA);
      chk("setup_word", r[15:0], sie.mem[i]);
    end
    wr(UEPB_IDX_SEL, 16'h0000);
    wr(UEPB_IDX_CTRL, 16'h0006);
    @(posedge sys_clk);
    chk("go_ack", {14'h0, control_data_stage_go, ep0_status_ack}, 16'h3);
    sie.pulse(3'h1);
    chk("status_end", {14'h0, control_data_stage_go, ep0_status_ack}, 16'h2);
    wr(UEPB_IDX_CTRL, 16'h0006);
    sie.pulse(3'h2);
    chk("setup_clr", {14'h0, control_data_stage_go, ep0_status_ack}, 16'h0);
    wr(UEPB_IDX_SEL, 16'h0006);
    wr(UEPB_IDX_PKT_LEN, 16'h0032);
    usb_bus_reset <= 1'b1;
    @(posedge sys_clk);
    usb_bus_reset <= 1'b0;
    wr(UEPB_IDX_SEL, 16'h0006);
    rd(UEPB_IDX_PKT_LEN);
    chk("len_busrst", r[15:0], 16'h0000);
    final_report();
  end
endmodule
